// [rtl/dsc_pkg.sv]
// package: dram strobe controller constants and types
package dsc_pkg;
  // ---------------------------------------------------------------
  // timing in ns and derived cycles at 50 MHz
  // ---------------------------------------------------------------
  localparam int CLK_NS               = 20;
  localparam int ROW_TO_COL_NS        = 20;   // row_to_column_strobe_delay min
  localparam int ACCESS_ROW_NS        = 100;  // access_from_row_strobe
  localparam int ACCESS_COL_NS        = 50;   // access_from_column_strobe
  localparam int ROW_PULSE_NS         = 115;
  localparam int COL_PULSE_NS         = 60;
  localparam int ROW_PRECHARGE_NS     = 110;  // row_precharge_time
  localparam int RANDOM_CYCLE_NS      = 235;  // random_cycle_time
  localparam int PAGE_CYCLE_NS        = 130;  // page_cycle_time
  localparam int COL_PRECHARGE_NS     = 60;
  localparam int REFRESH_INTERVAL_NS  = 2000000;
  localparam int ROW_COUNT            = 128;
  localparam int INIT_CYCLES          = 8;
  localparam int RCD_CYC  = (ROW_TO_COL_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC  = (ACCESS_ROW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAC_CYC  = (ACCESS_COL_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_CYC  = (ROW_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_CYC  = (COL_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC   = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_CYC   = (RANDOM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PC_CYC   = (PAGE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CP_CYC   = (COL_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  // spacing of refreshes, evenly spread, rounded down
  localparam int REF_GAP_CYC = REFRESH_INTERVAL_NS / ROW_COUNT / CLK_NS;
  localparam int ROW_BITS    = 7;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DSC_RD, DSC_WR, DSC_RMW} dsc_op_t;
  typedef struct packed {
    dsc_op_t             op;
    logic [2*ROW_BITS-1:0] addr;
    logic                wdata;
    logic                page;   // keep row open for a further access
  } dsc_req_t;
  typedef struct packed {
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [ROW_BITS-1:0] addr;
    logic                din;
  } dsc_pins_t;
endpackage : dsc_pkg

// [rtl/dsc_ctrl.sv]
// module: host controller driving a 16k x 1 strobed dynamic ram
// Summary of operation
// - eight refresh cycles before first access
// - all 128 rows refreshed each 2 ms
// - refresh by row strobe only
// - write strobe high throughout a read
// - column strobe 20 ns after row strobe
// - late write after column/row delays: modify-write
// - column-to-row precharge after column-only cycle
// - minimum strobe widths, under 10 us active
// - random cycles spaced by cycle time
// - page accesses spaced by page cycle time
// - row then column halves on seven pins
`timescale 1ns/1ns
module dsc_ctrl #(
  parameter int REF_GAP = dsc_pkg::REF_GAP_CYC
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // request side
  input  wire logic             req_valid,
  input  wire dsc_pkg::dsc_req_t req,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output logic                  rsp_data,
  // memory pins
  output dsc_pkg::dsc_pins_t    pins,
  input  wire logic             dout
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {S_INIT, S_IDLE, S_ROW, S_COL, S_LATE, S_CASH,
                            S_RASH, S_PRE, S_REF} dsc_state_t;
  dsc_state_t state, next_state;
  logic [7:0]  cnt, next_cnt;          // phase timer within a cycle
  logic [7:0]  rcyc, next_rcyc;        // timer since row strobe fell
  logic [31:0] rgap, next_rgap;        // refresh spacing timer
  logic [7:0]  rpend, next_rpend;      // refreshes owed
  logic [dsc_pkg::ROW_BITS-1:0] rrow, next_rrow;
  logic [3:0]  init, next_init;
  dsc_pkg::dsc_req_t cur, next_cur;
  dsc_pkg::dsc_pins_t next_pins;
  logic next_req_ready, next_rsp_valid, next_rsp_data;

  function automatic logic [7:0] c8(input int v);
    return v[7:0];
  endfunction : c8

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_cnt       = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    next_rcyc      = (rcyc != 8'hFF) ? rcyc + 8'h01 : rcyc;
    next_rgap      = rgap;
    next_rpend     = rpend;
    next_rrow      = rrow;
    next_init      = init;
    next_cur       = cur;
    next_pins      = pins;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    // evenly spaced refresh tick; owed count never lost to a concurrent service
    if (rgap == 32'h0) begin
      next_rgap = 32'(REF_GAP - 1);
      if (rpend != 8'hFF) next_rpend = rpend + 8'h01;
    end else begin
      next_rgap = rgap - 32'h1;
    end
    case (state)
      S_INIT: begin
        // power-up: row-only cycles before any access
        if (init == 4'(dsc_pkg::INIT_CYCLES)) begin
          next_state = S_IDLE;
        end else if (cnt == 8'h00) begin
          next_init  = init + 4'h1;
          next_state = S_REF;
          next_pins.addr  = rrow;
          next_pins.ras_n = 1'b0;
          next_cnt   = c8(dsc_pkg::RAS_CYC - 1);
          next_rcyc  = 8'h00;
        end
      end
      S_IDLE: begin
        // an offered ready is always honoured; a refresh waits one access
        if (req_valid && req_ready) begin
          next_cur        = req;
          next_pins.addr  = req.addr[dsc_pkg::ROW_BITS-1:0];
          next_pins.ras_n = 1'b0;
          next_pins.cas_n = 1'b1;
          next_pins.we_n  = 1'b1;
          next_pins.din   = req.wdata;
          next_cnt        = c8(dsc_pkg::RCD_CYC - 1);
          next_rcyc       = 8'h00;
          next_state      = S_ROW;
        end else if (cnt == 8'h00 && rpend != 8'h00) begin
          // refresh wins unless an offered ready is being taken, row strobe only
          next_state      = S_REF;
          next_pins.addr  = rrow;
          next_pins.ras_n = 1'b0;
          next_pins.cas_n = 1'b1;
          next_cnt        = c8(dsc_pkg::RAS_CYC - 1);
          next_rcyc       = 8'h00;
        end else if (cnt == 8'h00) begin
          next_req_ready = 1'b1;
        end
      end
      S_ROW: begin
        // column half after row to column delay
        if (cnt == 8'h00) begin
          next_pins.addr  = cur.addr[2*dsc_pkg::ROW_BITS-1:dsc_pkg::ROW_BITS];
          next_pins.cas_n = 1'b0;
          next_pins.we_n  = (cur.op == dsc_pkg::DSC_WR) ? 1'b0 : 1'b1;
          next_pins.din   = cur.wdata;
          next_cnt        = c8(dsc_pkg::CAC_CYC > dsc_pkg::CAS_CYC ?
                               dsc_pkg::CAC_CYC : dsc_pkg::CAS_CYC);
          next_state      = S_COL;
        end
      end
      S_COL: begin
        // data valid after longer of row and column access
        if (cnt == 8'h00 && rcyc >= c8(dsc_pkg::ACC_CYC)) begin
          if (cur.op != dsc_pkg::DSC_WR) begin
            next_rsp_valid = 1'b1;
            next_rsp_data  = dout;
          end else begin
            next_rsp_valid = 1'b1;
          end
          if (cur.op == dsc_pkg::DSC_RMW) begin
            next_pins.we_n = 1'b0;
            next_cnt       = c8(dsc_pkg::CAS_CYC);
            next_state     = S_LATE;
          end else begin
            next_pins.cas_n = 1'b1;
            next_pins.we_n  = 1'b1;
            next_cnt        = c8(dsc_pkg::CP_CYC - 1);
            next_state      = S_CASH;
          end
        end
      end
      S_LATE: begin
        if (cnt == 8'h00) begin
          next_pins.cas_n = 1'b1;
          next_pins.we_n  = 1'b1;
          next_cnt        = c8(dsc_pkg::CP_CYC - 1);
          next_state      = S_CASH;
        end
      end
      S_CASH: begin
        // page continuation keeps the row open; rcyc keeps counting from the
        // row fall, so a saturated timer closes the page far below the maximum
        if (req_valid && req_ready) begin
          next_cur        = req;
          next_pins.addr  = req.addr[2*dsc_pkg::ROW_BITS-1:dsc_pkg::ROW_BITS];
          next_pins.cas_n = 1'b0;
          next_pins.we_n  = (req.op == dsc_pkg::DSC_WR) ? 1'b0 : 1'b1;
          next_pins.din   = req.wdata;
          next_cnt        = c8(dsc_pkg::PC_CYC - dsc_pkg::CP_CYC);
          next_state      = S_COL;
        end else if (cnt == 8'h00) begin
          if (cur.page && rpend == 8'h00 && rcyc != 8'hFF) begin
            next_req_ready = 1'b1;
          end else begin
            next_state = S_RASH;
          end
        end
      end
      S_RASH: begin
        // release row strobe once its pulse floor RAS_CYC is met; the cycle floor is left to S_PRE
        // read data is held in rsp_data, so cas need not stay low here
        if (rcyc >= c8(dsc_pkg::RAS_CYC)) begin
          next_pins.ras_n = 1'b1;
          next_cnt        = c8(dsc_pkg::RP_CYC - 1);
          next_state      = S_PRE;
        end
      end
      S_REF: begin
        if (cnt == 8'h00) begin
          next_pins.ras_n = 1'b1;
          next_rrow       = rrow + 1'b1;
          if (rpend != 8'h00 && !(rgap == 32'h0)) next_rpend = rpend - 8'h01;
          else if (rpend != 8'h00) next_rpend = rpend;
          next_cnt        = c8(dsc_pkg::RP_CYC - 1);
          next_state      = S_PRE;
        end
      end
      S_PRE: begin
        // precharge and whole random cycle both satisfied
        if (cnt == 8'h00 && rcyc >= c8(dsc_pkg::RC_CYC - 1)) begin
          next_state = (init == 4'(dsc_pkg::INIT_CYCLES)) ? S_IDLE : S_INIT;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state     <= S_INIT;
      cnt       <= 8'h00;
      rcyc      <= 8'hFF;
      rgap      <= 32'h0;
      rpend     <= 8'h00;
      rrow      <= '0;
      init      <= 4'h0;
      cur       <= '0;
      pins      <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: '0, din: 1'b0};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 1'b0;
    end else if (clk_en) begin
      state     <= next_state;
      cnt       <= next_cnt;
      rcyc      <= next_rcyc;
      rgap      <= next_rgap;
      rpend     <= next_rpend;
      rrow      <= next_rrow;
      init      <= next_init;
      cur       <= next_cur;
      pins      <= next_pins;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
    end
  end
endmodule : dsc_ctrl

// [tb/dsc_ctrl_checker.sv]
// checker: strobe timing of the dram controller
`timescale 1ns/1ns
module dsc_ctrl_checker #(
  parameter int REF_GAP = dsc_pkg::REF_GAP_CYC
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // watched outputs
  input wire logic               req_ready,
  input wire logic               rsp_valid,
  input wire dsc_pkg::dsc_pins_t pins
);
  // ---------------------------------------------------------------
  // cycles since strobe edges, saturating so long idles stay sane
  // ---------------------------------------------------------------
  logic        ras_q;
  logic        cas_q;
  logic [15:0] since_ras;
  logic [15:0] since_cas;
  logic [15:0] ras_low;
  logic [3:0]  nref;
  wire         ras_fall = ras_q & ~pins.ras_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ras_q     <= 1'b1;
      cas_q     <= 1'b1;
      since_ras <= 16'h03E8;
      since_cas <= 16'h03E8;
      ras_low   <= 16'h0000;
      nref      <= 4'h0;
    end else begin
      ras_q     <= pins.ras_n;
      cas_q     <= pins.cas_n;
      since_ras <= ras_fall ? 16'h0001 : since_ras + {15'h0000, ~&since_ras};
      since_cas <= (cas_q & ~pins.cas_n) ? 16'h0001 : since_cas + {15'h0000, ~&since_cas};
      ras_low   <= pins.ras_n ? 16'h0000 : ras_low + 16'h0001;
      nref      <= nref + {3'h0, ras_fall & (nref != 4'h8)};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  cas_after_ras_a: assert property (
    $fell(pins.cas_n) |-> !$past(pins.ras_n)) else $error("column strobe without row strobe");
  ras_width_a: assert property (
    $fell(pins.ras_n) |-> (!pins.ras_n) [*6]) else $error("row strobe pulse too short");
  cas_width_a: assert property (
    $fell(pins.cas_n) |-> (!pins.cas_n) [*3]) else $error("column strobe pulse too short");
  ras_precharge_a: assert property (
    $rose(pins.ras_n) |-> pins.ras_n [*6]) else $error("row precharge too short");
  cycle_time_a: assert property (
    ras_fall |-> since_ras >= 16'h000C) else $error("random cycles too close");
  page_cycle_a: assert property (
    $fell(pins.cas_n) |-> since_cas >= 16'h0007) else $error("column accesses too close");
  write_strobe_a: assert property (
    $fell(pins.we_n) |-> !pins.cas_n) else $error("write strobe outside column strobe");
  rmw_delay_a: assert property (
    $fell(pins.we_n) && !$past(pins.cas_n) |-> since_cas >= 16'h0003 && since_ras >= 16'h0005)
    else $error("late write too early");
  init_refresh_a: assert property (
    req_ready |-> nref == 4'h8) else $error("request offered before eight refreshes");
  access_time_a: assert property (
    rsp_valid |-> since_ras >= 16'h0005) else $error("answer before row access time");
  ras_max_a: assert property (
    ras_low < 16'h01F4) else $error("row strobe held too long");
  refresh_gap_a: assert property (
    nref == 4'h8 |-> since_ras <= REF_GAP + 80) else $error("refresh overdue");
endmodule : dsc_ctrl_checker

bind dsc_ctrl dsc_ctrl_checker #(.REF_GAP(REF_GAP)) chk_i (.clk_sys(clk_sys), .resetn(resetn),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins));

// [tb/dsc_dram_model.sv]
// device model: behavioural 16k x 1 strobed dram
`timescale 1ns/1ns
module dsc_dram_model (
  input  wire logic               clk_sys,
  input  wire dsc_pkg::dsc_pins_t pins,
  output logic                    dout
);
  logic       mem [16384];
  logic [6:0] row;
  logic [6:0] col;
  logic       ras_q = 1'b1;
  logic       cas_q = 1'b1;
  logic       we_q  = 1'b1;
  logic       early = 1'b0;
  logic       junk  = 1'b0;
  int         rcnt  = 0;
  int         ccnt  = 0;
  // released output toggles, so a stale level never passes for data
  wire        drive = !pins.cas_n && !early && rcnt >= 4 && ccnt >= 2;
  assign dout = drive ? mem[{col, row}] : junk;
  always @(posedge clk_sys) begin
    ras_q <= pins.ras_n;
    cas_q <= pins.cas_n;
    we_q  <= pins.we_n;
    junk  <= ~junk;
    rcnt  <= pins.ras_n ? 0 : rcnt + 1;
    ccnt  <= pins.cas_n ? 0 : ccnt + 1;
    if (ras_q && !pins.ras_n) begin
      row <= pins.addr;
    end
    if (cas_q && !pins.cas_n) begin
      col   <= pins.addr;
      early <= !pins.we_n;
      if (!pins.we_n) begin
        mem[{pins.addr, row}] <= pins.din;
      end
    end
    if (we_q && !pins.we_n && !cas_q) begin
      mem[{col, row}] <= pins.din;
    end
  end
endmodule : dsc_dram_model

// [tb/dsc_ctrl_tb.sv]
// testbench: controller against the behavioural dram
`timescale 1ns/1ns
module dsc_ctrl_tb;
  localparam int GAP = 40;
  localparam logic [13:0] TAB [6] = '{14'h0000, 14'h3FFF, 14'h007F, 14'h3F80, 14'h1555, 14'h2AAA};
  logic               clk_sys   = 1'b0;
  logic               resetn    = 1'b0;
  logic               clk_en    = 1'b1;
  logic               req_valid = 1'b0;
  dsc_pkg::dsc_req_t  req       = '0;
  logic               req_ready;
  logic               rsp_valid;
  logic               rsp_data;
  logic               dout;
  dsc_pkg::dsc_pins_t pins;
  logic               ras_q     = 1'b1;
  logic [127:0]       seen      = '0;
  logic               got;
  int                 errors      = 0;
  int                 comparisons = 0;
  dsc_ctrl #(.REF_GAP(GAP)) dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .pins(pins), .dout(dout));
  dsc_dram_model ram (.clk_sys(clk_sys), .pins(pins), .dout(dout));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    ras_q <= pins.ras_n;
    if (ras_q && pins.ras_n === 1'b0) begin
      seen[pins.addr] <= 1'b1;
    end
  end
  task automatic chk(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk
  // request held until taken or 2000 cycles pass, then bounded wait for the answer
  task automatic access(input dsc_pkg::dsc_op_t op, input logic [13:0] a, input logic d,
                        input logic pg, output logic q);
    int n;
    req = '{op, a, d, pg};
    req_valid = 1'b1;
    for (n = 0; n < 2000 && req_ready !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    for (n = 0; n < 200 && rsp_valid !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    q = rsp_data;
    chk("answer", 1'b1, rsp_valid);
  endtask : access
  task automatic t_rw;
    for (int i = 0; i < 6; i++) begin
      access(dsc_pkg::DSC_WR, TAB[i], i[0], 1'b0, got);
    end
    for (int i = 0; i < 6; i++) begin
      access(dsc_pkg::DSC_RD, TAB[i], 1'b0, 1'b0, got);
      chk("read back", i[0], got);
    end
  endtask : t_rw
  task automatic t_rmw;
    access(dsc_pkg::DSC_RMW, TAB[3], 1'b0, 1'b0, got);
    chk("rmw old data", 1'b1, got);
    access(dsc_pkg::DSC_RD, TAB[3], 1'b0, 1'b0, got);
    chk("rmw new data", 1'b0, got);
  endtask : t_rmw
  task automatic t_page;
    for (int i = 0; i < 3; i++) begin
      access(dsc_pkg::DSC_WR, {i[6:0] + 7'h10, 7'h05}, ~i[0], i < 2, got);
    end
    for (int i = 0; i < 3; i++) begin
      access(dsc_pkg::DSC_RD, {i[6:0] + 7'h10, 7'h05}, 1'b0, i < 2, got);
      chk("page read", ~i[0], got);
    end
  endtask : t_page
  task automatic t_freeze;
    fork
      access(dsc_pkg::DSC_RD, TAB[1], 1'b0, 1'b0, got);
      begin
        @(negedge req_valid);
        repeat (2) @(posedge clk_sys);
        #1;
        clk_en = 1'b0;
        repeat (30) @(posedge clk_sys);
        #1;
        clk_en = 1'b1;
      end
    join
    chk("frozen read", 1'b1, got);
  endtask : t_freeze
  task automatic t_refresh;
    seen = '0;
    repeat (128 * GAP + 400) @(posedge clk_sys);
    #1;
    chk("all rows refreshed", 1'b1, &seen);
  endtask : t_refresh
  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    chk("row strobe in reset", 1'b1, pins.ras_n);
    chk("column strobe in reset", 1'b1, pins.cas_n);
    chk("ready in reset", 1'b0, req_ready);
    resetn = 1'b1;
    t_rw();
    t_rmw();
    t_page();
    t_freeze();
    t_refresh();
    finish_test();
  end
  initial begin
    #400000;
    errors++;
    finish_test();
  end
endmodule : dsc_ctrl_tb
